// ### design/aux_seq_pkg.sv
// constants and types for the step-0 configuration register of the aux converter sequencer
// assumes a single 50 MHz clock domain and a plain address/strobe register port
package aux_seq_pkg;
   localparam int          ADDR_W           = 8;
   localparam int          DATA_W           = 16;
   localparam logic [7:0]  STEP_ZERO_OFFSET = 8'h90;
   localparam logic [7:0]  SETTLE_OFFSET    = 8'h8c;
   localparam logic [15:0] STEP_ZERO_RESET  = 16'h0000;
   localparam logic [15:0] SETTLE_RESET     = 16'h0000;
   localparam int          ENABLE_BIT       = 15;
   localparam int          GAIN_HI          = 14;
   localparam int          GAIN_LO          = 13;
   localparam int          NEG_BIT          = 4;
   localparam int          POS_HI           = 3;
   localparam int          POS_LO           = 0;
   localparam int          DELAY_HI         = 10;
   localparam int          DELAY_LO         = 8;
   localparam logic [15:0] STEP_ZERO_MASK   = 16'he01f;
   localparam logic [15:0] SETTLE_MASK      = 16'h0700;
   localparam int          DELAY_BASE_LOG2  = 4;
   localparam int          DELAY_CNT_W      = 13;

   localparam logic [3:0] POS_TEMP    = 4'h8;
   localparam logic [3:0] POS_SHORT   = 4'h9;
   localparam logic [3:0] POS_AVDD4   = 4'hb;
   localparam logic [3:0] POS_IOVDD4  = 4'hc;

   typedef enum logic [1:0] {
      GAIN_ONE  = 2'h1,
      GAIN_TWO  = 2'h2,
      GAIN_FOUR = 2'h3
   } gain_t;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'h1,
      ST_SETTLE = 3'h2,
      ST_READY  = 3'h4
   } seq_state_t;
endpackage

// ### design/settle_if.sv
// carries the settle-delay request and completion between sequencer control and the timer
// assumes both ends run on the same clock
`timescale 1ns/1ns
`default_nettype none
interface settle_if;
   logic       start;
   logic [2:0] code;
   logic       done;
   modport ctrl  (output start, output code, input done);
   modport timer (input start, input code, output done);
endinterface
`default_nettype wire

// ### design/settle_timer.sv
// settle-delay counter: 16 cycles for code 0, 32 << code cycles for every longer setting
// assumes start is a one-cycle pulse from logic on the same clock
`timescale 1ns/1ns
`default_nettype none
module settle_timer
   import aux_seq_pkg::*;
(
   input  wire logic mclk,    // master clock
   input  wire logic rst_n,   // async reset, active low
   settle_if.timer   link     // request and completion
);
   typedef struct packed {
      logic                   busy;
      logic [DELAY_CNT_W-1:0] count;
      logic                   done;
   } timer_t;

   timer_t cur;
   timer_t next_cur;

   always_comb begin
      next_cur      = cur;
      next_cur.done = 1'b0;
      if (link.start) begin
         // count reloads to length minus one so done lands exactly on the last cycle
         next_cur.busy  = 1'b1;
         // lengths run 16, 64, 128 ... 4096: code 0 is the only one off the doubling from 32
         next_cur.count = DELAY_CNT_W'((32'h1 << (DELAY_BASE_LOG2 + int'(link.code)
                          + int'(link.code != 3'h0))) - 32'h1);
      end else if (cur.busy) begin
         if (cur.count == '0) begin
            next_cur.busy = 1'b0;
            next_cur.done = 1'b1;
         end else begin
            next_cur.count = cur.count - DELAY_CNT_W'(1);
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign link.done = cur.done;
endmodule
`default_nettype wire

// ### design/aux_seq_step_zero.sv
// step-0 configuration register of the aux converter sequencer, plus the settle delay
// assumes a host on the same clock issuing one-cycle read/write strobes
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - bit 15 set enables sequencer step 0; clear disables it
// - gain field 14:13: 00 gain 1, 01 gain 2, 10 and 11 gain 4
// - bit 4 picks negative input: 0 analog ground, 1 external input seven
// - positive field 3:0 codes 0 to 7 select external inputs 0 to 7
// - code 8 temperature sensor, code 9 internal short; negative automatic
// - code 11 analog supply over four, code 12 io supply over four
// - settle delay before next step conversion; code 0 is 16 cycles
module aux_seq_step_zero
   import aux_seq_pkg::*;
(
   input  wire logic                  mclk,          // master clock, 50 MHz
   input  wire logic                  rst_n,         // async reset, active low
   input  wire logic [ADDR_W-1:0]     regAddr,       // register address
   input  wire logic [DATA_W-1:0]     regWdata,      // write data
   input  wire logic                  regWr,         // write strobe
   input  wire logic                  regRd,         // read strobe
   output logic [DATA_W-1:0]          regRdata,      // read data, cycle after strobe
   input  wire logic                  stepRequest,   // sequencer asks to run step 0
   output logic                       stepEnable,    // step 0 enabled
   output aux_seq_pkg::gain_t         gainSel,       // decoded gain
   output logic [3:0]                 positiveInput, // positive mux code
   output logic                       negExternal,   // negative input is external input seven
   output logic                       negAuto,       // negative input chosen internally
   output logic                       convertStart,  // pulse: settle over, convert now
   output logic                       stepSkipped    // pulse: request seen while disabled
);
   typedef struct packed {
      logic [DATA_W-1:0] stepCfg;
      logic [DATA_W-1:0] settleCfg;
      logic [DATA_W-1:0] rdata;
      seq_state_t        state;
      logic              start;
      logic              skip;
      logic              convert;
   } core_t;

   core_t    cur;
   core_t    next_cur;
   settle_if settle ();

   logic [3:0] pos;
   logic       isAuto;

   // refuse package values that the fixed field layout below cannot serve
   if (DATA_W != 16) begin : g_bad_data_w
      $error("step register must be 16 bits wide");
   end

   if (ADDR_W < 8) begin : g_bad_addr_w
      $error("register address must hold an 8-bit offset");
   end

   if (ENABLE_BIT >= DATA_W) begin : g_bad_enable
      $error("enable bit lies outside the register");
   end

   if (GAIN_HI != GAIN_LO + 1) begin : g_bad_gain
      $error("gain field must be two bits wide");
   end

   if (POS_HI - POS_LO != 3) begin : g_bad_pos
      $error("positive input field must be four bits wide");
   end

   if (DELAY_HI - DELAY_LO != 2) begin : g_bad_delay
      $error("settle delay field must be three bits wide");
   end

   // longest setting is 4096 cycles, reloaded as 4095
   if (DELAY_CNT_W < DELAY_BASE_LOG2 + 8) begin : g_bad_count
      $error("settle counter too narrow for the longest delay");
   end

   if (STEP_ZERO_OFFSET == SETTLE_OFFSET) begin : g_bad_offset
      $error("step and settle registers share one offset");
   end

   // isAuto looks at the top code bit only, so every internal source must have it set
   if (!POS_TEMP[3] || !POS_SHORT[3] || !POS_AVDD4[3] || !POS_IOVDD4[3]) begin : g_bad_auto
      $error("internal source code below eight");
   end

   // each writable bit belongs to a field; reserved bits neither store nor reset high
   for (genvar b = 0; b < DATA_W; b++) begin : g_mask_bit
      localparam bit IN_STEP  = (b == ENABLE_BIT) || (b == NEG_BIT)
                                || (b <= GAIN_HI && b >= GAIN_LO)
                                || (b <= POS_HI && b >= POS_LO);
      localparam bit IN_DELAY = (b <= DELAY_HI && b >= DELAY_LO);

      if (STEP_ZERO_MASK[b] != IN_STEP) begin : g_bad_step
         $error("step register mask disagrees with its fields");
      end

      if (SETTLE_MASK[b] != IN_DELAY) begin : g_bad_settle
         $error("settle register mask disagrees with its field");
      end

      if ((STEP_ZERO_RESET[b] && !IN_STEP) || (SETTLE_RESET[b] && !IN_DELAY)) begin : g_bad_reset
         $error("reset value sets a reserved bit");
      end
   end

   settle_timer u_timer (
      .mclk  (mclk),
      .rst_n (rst_n),
      .link  (settle.timer)
   );

   assign pos = cur.stepCfg[POS_HI:POS_LO];

   always_comb begin
      // codes above 7 are all internal sources with automatic negative input
      isAuto = pos[3];
      next_cur         = cur;
      next_cur.rdata   = '0;
      next_cur.start   = 1'b0;
      next_cur.skip    = 1'b0;
      next_cur.convert = 1'b0;

      if (regWr && regAddr == STEP_ZERO_OFFSET) begin
         next_cur.stepCfg = regWdata & STEP_ZERO_MASK;
      end
      if (regWr && regAddr == SETTLE_OFFSET) begin
         next_cur.settleCfg = regWdata & SETTLE_MASK;
      end
      // unmapped addresses read zero
      if (regRd) begin
         case (regAddr)
            STEP_ZERO_OFFSET: next_cur.rdata = cur.stepCfg;
            SETTLE_OFFSET:    next_cur.rdata = cur.settleCfg;
            default:          next_cur.rdata = '0;
         endcase
      end

      case (cur.state)
         ST_IDLE: begin
            if (stepRequest) begin
               if (cur.stepCfg[ENABLE_BIT]) begin
                  next_cur.start = 1'b1;
                  next_cur.state = ST_SETTLE;
               end else begin
                  next_cur.skip = 1'b1;
               end
            end
         end
         ST_SETTLE: begin
            if (settle.done) begin
               next_cur.convert = 1'b1;
               next_cur.state   = ST_READY;
            end
         end
         ST_READY: begin
            next_cur.state = ST_IDLE;
         end
         default: begin
            next_cur.state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cur.stepCfg   <= STEP_ZERO_RESET;
         cur.settleCfg <= SETTLE_RESET;
         cur.rdata     <= '0;
         cur.state     <= ST_IDLE;
         cur.start     <= 1'b0;
         cur.skip      <= 1'b0;
         cur.convert   <= 1'b0;
      end else begin
         cur <= next_cur;
      end
   end

   assign settle.start = cur.start;
   assign settle.code  = cur.settleCfg[DELAY_HI:DELAY_LO];

   always_comb begin
      case (cur.stepCfg[GAIN_HI:GAIN_LO])
         2'h0:    gainSel = GAIN_ONE;
         2'h1:    gainSel = GAIN_TWO;
         default: gainSel = GAIN_FOUR;
      endcase
   end

   assign regRdata      = cur.rdata;
   assign stepEnable    = cur.stepCfg[ENABLE_BIT];
   assign positiveInput = pos;
   assign negAuto       = isAuto;
   assign negExternal   = cur.stepCfg[NEG_BIT] && !isAuto;
   assign convertStart  = cur.convert;
   assign stepSkipped   = cur.skip;
endmodule
`default_nettype wire

// ### sim/aux_seq_step_zero_monitor.sv
// checker for the step-0 configuration register ports
// assumes one clock domain, reset asynchronous active low
`timescale 1ns/1ns
`default_nettype none
module aux_seq_step_zero_chk
   import aux_seq_pkg::*;
(
   input wire logic        mclk,          // clock
   input wire logic        rst_n,         // reset
   input wire logic [7:0]  regAddr,       // address
   input wire logic [15:0] regWdata,      // write data
   input wire logic        regWr,         // write strobe
   input wire logic        regRd,         // read strobe
   input wire logic [15:0] regRdata,      // read data
   input wire logic        stepRequest,   // request
   input wire logic        stepEnable,    // enable
   input wire gain_t       gainSel,       // gain
   input wire logic [3:0]  positiveInput, // positive code
   input wire logic        negExternal,   // negative external
   input wire logic        negAuto,       // negative automatic
   input wire logic        convertStart,  // convert pulse
   input wire logic        stepSkipped    // skip pulse
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   wire cfgWr = regWr && regAddr == STEP_ZERO_OFFSET;
   chk_enable_bit: assert property (cfgWr |=> stepEnable == $past(regWdata[15]))
      else $error("enable bit wrong");
   chk_gain_decode: assert property (
      cfgWr |=> gainSel == ($past(regWdata[14:13]) == 2'h0 ? GAIN_ONE :
      $past(regWdata[14:13]) == 2'h1 ? GAIN_TWO : GAIN_FOUR))
      else $error("gain decode wrong");
   chk_neg_select: assert property (
      cfgWr |=> negExternal == ($past(regWdata[4]) && !$past(regWdata[3])))
      else $error("negative select wrong");
   chk_pos_field: assert property (cfgWr |=> positiveInput == $past(regWdata[3:0]))
      else $error("positive field wrong");
   chk_auto_neg: assert property (
      negAuto == positiveInput[3] && !(negAuto && negExternal))
      else $error("automatic negative wrong");
   chk_reserved_zero: assert property (
      regRd && regAddr == STEP_ZERO_OFFSET |=> regRdata[12:5] == 8'h00)
      else $error("reserved bits not zero");
   chk_rdata_idle: assert property (!regRd |=> regRdata == 16'h0000)
      else $error("read data outside slot");
   chk_skip_pulse: assert property (
      stepRequest && !stepEnable |=> stepSkipped ##1 !stepSkipped)
      else $error("skip pulse wrong");
   chk_convert_pulse: assert property (convertStart |=> !convertStart)
      else $error("convert pulse too long");
   cover property (cfgWr);
   cover property (convertStart);
   cover property (stepSkipped);
endmodule
bind aux_seq_step_zero aux_seq_step_zero_chk aux_seq_step_zero_chk_inst (.mclk, .rst_n, .regAddr,
   .regWdata, .regWr, .regRd, .regRdata, .stepRequest, .stepEnable, .gainSel, .positiveInput,
   .negExternal, .negAuto, .convertStart, .stepSkipped);
`default_nettype wire

// ### sim/test_aux_seq_step_zero.sv
// testbench for the step-0 configuration register
// assumes the checker is bound separately
`timescale 1ns/1ns
`default_nettype none
module test_aux_seq_step_zero;
   import aux_seq_pkg::*;
   logic mclk = 0, rst_n = 0, regWr = 0, regRd = 0, stepRequest = 0;
   logic [7:0] regAddr = 8'h00;
   logic [15:0] regWdata = 16'h0000, regRdata;
   logic stepEnable, negExternal, negAuto, convertStart, stepSkipped;
   logic [3:0] positiveInput;
   gain_t gainSel;
   int errTotal = 0, samplesChecked = 0, n;
   aux_seq_step_zero aux_seq_step_zero_inst (.mclk, .rst_n, .regAddr, .regWdata, .regWr, .regRd,
      .regRdata, .stepRequest, .stepEnable, .gainSel, .positiveInput, .negExternal, .negAuto,
      .convertStart, .stepSkipped);
   initial forever #10 mclk = ~mclk;
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samplesChecked++;
      if (got !== exp) begin
         errTotal++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk) {regWr, regAddr, regWdata} <= {1'b1, a, d};
      @(posedge mclk) regWr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      @(posedge mclk) {regRd, regAddr} <= {1'b1, a};
      @(posedge mclk) regRd <= 1'b0;
      #1 chk(regRdata, exp);
   endtask
   task automatic request();
      @(posedge mclk) stepRequest <= 1'b1;
      @(posedge mclk) stepRequest <= 1'b0;
      #1;
   endtask
   task automatic completeRun();
      if (errTotal == 0 && samplesChecked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      #200000 errTotal++;
      completeRun();
   end
   initial begin
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      rd(8'h90, 16'h0000);
      rd(8'h8c, 16'h0000);
      wr(8'h90, 16'hffff);
      rd(8'h90, 16'he01f);
      chk({negAuto, negExternal, stepEnable}, 16'h5);
      wr(8'h20, 16'h0000);
      rd(8'h20, 16'h0000);
      rd(8'h90, 16'he01f);
      for (int g = 0; g < 4; g++) begin
         wr(8'h90, {1'b0, 2'(g), 13'h0010});
         chk(16'(gainSel), g == 0 ? 16'h1 : g == 1 ? 16'h2 : 16'h3);
         chk({stepEnable, negExternal}, 16'h1);
      end
      for (int p = 0; p < 16; p++) begin
         wr(8'h90, {12'h801, 4'(p)});
         chk(16'(positiveInput), 16'(p));
         chk({negAuto, negExternal}, {14'h0, p > 7, p < 8});
      end
      wr(8'h90, 16'h0000);
      request();
      chk(16'(stepSkipped), 16'h1);
      // request edge, timer start, delay, done pulse, convert: delay plus two cycles
      for (int c = 0; c < 2; c++) begin
         wr(8'h8c, {5'h0, 3'(c), 8'h00});
         wr(8'h90, 16'h8000);
         request();
         n = 0;
         while (convertStart !== 1'b1 && n < 100) begin
            @(posedge mclk) n++;
            #1;
         end
         chk(16'(n), c == 0 ? 16'h12 : 16'h42);
         chk(16'(stepSkipped), 16'h0);
      end
      completeRun();
   end
endmodule
`default_nettype wire
